// File: hdl/scri_ctrl.sv
// Purpose: system control, reset sequencing and interrupt arbitration
// Assumes: one clock sys_clk at 250 MHz, pins synchronised in here
// Notes:   cpu handshake signals are on sys_clk and need no sync
// Operation
// - halt enters sleep, or standby when selected
// - select code sets standby settling count
// - core and peripherals wait through settling count
// - source flag: pin reset sets, watchdog clears
// - edge select picks nonmaskable pin edge
// - host port enable drives host interface
// - ram enable, set by reset, kept in standby
// - mode status fixed bits read constant
// - mode bits latch mode pins on read
// - mode 1 fetches vectors off-chip, no rom
// - mode 2 address ports start as inputs
// - reset pin low resets after its two-stage sync, outranks interrupts
// - interrupts taken only at instruction boundaries
// - watchdog reset pulse lasts 518 cycles
// - reset sequence masks, inits, loads reset vector
// - all blocked until first non-cond-code instruction completes
// - fixed vector numbers in priority order
// - key request from eight maskable key inputs
// - maskable requests edge or level sensed
// - cpu mask holds off all but nonmaskable
// - highest pending request vector goes out
`default_nettype none

module scri_ctrl
  import scri_pkg::*;
#(
  parameter int unsigned SETTLE_0 = SCRI_SETTLE_0,
  parameter int unsigned SETTLE_1 = SCRI_SETTLE_1,
  parameter int unsigned SETTLE_2 = SCRI_SETTLE_2,
  parameter int unsigned SETTLE_3 = SCRI_SETTLE_3,
  parameter int unsigned SETTLE_4 = SCRI_SETTLE_4
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic [SCRI_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              external_reset_pin_n,
  input  wire logic              nmi_pin,
  input  wire logic [2:0]        external_request_lines_n,
  input  wire logic [7:0]        key_sense_inputs_n,
  input  wire logic              mode_pin_high,
  input  wire logic              mode_pin_low,
  input  wire logic              wdt_overflow,
  input  wire logic              wdt_reset_select,
  input  wire logic              wdt_irq_enable,
  input  wire logic              cpu_halt_exec,
  input  wire logic              cpu_instr_done,
  input  wire logic              cpu_cc_instr,
  input  wire logic              cpu_imask,
  output logic                   core_reset,
  output logic                   reset_seq_start,
  output logic [15:0]            reset_vector_addr,
  output logic                   int_take,
  output logic [7:0]             int_vector,
  output logic                   cpu_halted,
  output logic                   periph_halted,
  output logic                   host_port_enable,
  output logic                   internal_ram_enable,
  output logic                   rom_enable,
  output logic                   vectors_external,
  output logic                   ext_bus_enable,
  output logic                   addr_ports_default_in
);

  // two-stage pin synchronisers, stage one read only by stage two
  logic [13:0] pin_s1_reg;
  logic [13:0] pin_s2_reg;
  logic [13:0] pin_raw;
  assign pin_raw = {mode_pin_high, mode_pin_low, key_sense_inputs_n,
                    external_request_lines_n, nmi_pin};

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_s1_reg <= 14'h3FFF;
      pin_s2_reg <= 14'h3FFF;
    end else if (clk_en) begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // external reset pin also synchronised on its own pair
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else if (clk_en) begin
      rst_s1_reg <= external_reset_pin_n;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  wire       nmi_s   = pin_s2_reg[0];
  wire [2:0] irq_s_n = pin_s2_reg[3:1];
  wire [7:0] key_s_n = pin_s2_reg[11:4];
  wire [1:0] mode_s  = pin_s2_reg[13:12];
  wire       pin_rst = ~rst_s2_reg;

  // watchdog reset pulse counter
  logic [9:0] wdt_cnt_reg;
  logic       core_reset_d_reg;
  wire        wdt_rst_go = wdt_overflow & wdt_reset_select;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wdt_cnt_reg <= 10'h000;
    end else if (clk_en) begin
      if (pin_rst) wdt_cnt_reg <= 10'h000;
      else if (wdt_rst_go && wdt_cnt_reg == 10'h000) wdt_cnt_reg <= SCRI_WDT_RST_CYC;
      else if (wdt_cnt_reg != 10'h000) wdt_cnt_reg <= wdt_cnt_reg - 10'h001;
    end
  end

  // pin reset acts ahead of everything
  // pin width is the driver's duty
  assign core_reset = reset | pin_rst | (wdt_cnt_reg != 10'h000);

  // reset release edge starts the sequence
  // mask, init, fetch reset vector
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      core_reset_d_reg  <= 1'b1;
      reset_seq_start   <= 1'b0;
      reset_vector_addr <= SCRI_RST_VADDR;
    end else if (clk_en) begin
      core_reset_d_reg  <= core_reset;
      reset_seq_start   <= core_reset_d_reg & ~core_reset;
      reset_vector_addr <= SCRI_RST_VADDR;
    end
  end

  // bus slave: one wait state then answer
  logic        ack_reg;
  logic [31:0] rdata_next;
  wire         bus_req  = avs_read | avs_write;
  wire         bus_fire = bus_req & ack_reg & clk_en;
  wire         wr_fire  = bus_fire & avs_write & avs_byteenable[0];
  wire         rd_fire  = bus_fire & avs_read;
  wire [15:0]  reg_idx  = avs_address[SCRI_AW-1:2];
  wire         hit_sc   = reg_idx == SCRI_IDX_SYSCTL;
  wire         hit_md   = reg_idx == SCRI_IDX_MODE;
  wire         hit_sn   = reg_idx == SCRI_IDX_SENSE;
  wire         hit_en   = reg_idx == SCRI_IDX_ENABLE;
  wire         hit_km   = reg_idx == SCRI_IDX_KMASK;
  wire [7:0]   wbyte    = avs_writedata[7:0];

  assign avs_waitrequest = bus_req & ~(ack_reg & clk_en);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_reg      <= bus_req & ~ack_reg;
      avs_readdata <= rdata_next;
    end
  end

  // software registers
  logic [7:0] sysctl_reg;
  logic [7:0] sense_reg;
  logic [7:0] enable_reg;
  logic [7:0] kmask_reg;
  logic [1:0] mode_reg;

  wire src_next = pin_rst ? 1'b1 : (wdt_cnt_reg != 10'h000) ? 1'b0
                : sysctl_reg[SCRI_SC_SRC];
  wire [7:0] sc_wr = (wbyte & SCRI_SC_WMASK) | {4'h0, src_next, 3'h0};
  wire [7:0] sc_ld = {sysctl_reg[7:4], src_next, sysctl_reg[2:0]};

  // control registers, reinitialised by any internal reset
  // ram enable set by reset, also writable by software
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sysctl_reg <= SCRI_SC_RST;
      sense_reg  <= SCRI_IRQ_RST;
      enable_reg <= SCRI_IRQ_RST;
      kmask_reg  <= SCRI_KMASK_RST;
    end else if (clk_en) begin
      if (core_reset) begin
        sysctl_reg <= (SCRI_SC_RST & ~8'h08) | {4'h0, src_next, 3'h0};
        sense_reg  <= SCRI_IRQ_RST;
        enable_reg <= SCRI_IRQ_RST;
        kmask_reg  <= SCRI_KMASK_RST;
      end else begin
        sysctl_reg <= (wr_fire && hit_sc) ? sc_wr : sc_ld;
        if (wr_fire && hit_sn) sense_reg <= wbyte | SCRI_IRQ_RSVD;
        if (wr_fire && hit_en) enable_reg <= wbyte | SCRI_IRQ_RSVD;
        if (wr_fire && hit_km) kmask_reg <= wbyte;
      end
    end
  end

  // mode bits caught after reset and on every read
  // latch pins when read
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_reg <= 2'b11;
    end else if (clk_en) begin
      if (core_reset || (rd_fire && hit_md)) mode_reg <= mode_s;
    end
  end

  // read mux; unmapped reads return zero, writes ignored
  // fixed mode status bits
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (avs_read && !ack_reg) begin
      if (hit_sc) rdata_next[7:0] = sysctl_reg;
      if (hit_md) rdata_next[7:0] = SCRI_MODE_FIX | {6'h00, mode_s};
      if (hit_sn) rdata_next[7:0] = sense_reg;
      if (hit_en) rdata_next[7:0] = enable_reg;
      if (hit_km) rdata_next[7:0] = kmask_reg;
    end
  end

  // mode decode for memory and port steering
  // mode 1 external vectors
  // mode 2 address ports as inputs
  assign rom_enable            = mode_reg != 2'b01;
  assign vectors_external      = mode_reg == 2'b01;
  assign ext_bus_enable        = mode_reg == 2'b01 || mode_reg == 2'b10;
  assign addr_ports_default_in = mode_reg == 2'b10;

  assign host_port_enable    = sysctl_reg[SCRI_SC_HOST];
  assign internal_ram_enable = sysctl_reg[SCRI_SC_RAM];

  // nonmaskable edge detect on synchronised level
  logic nmi_d_reg;
  logic nmi_pend_reg;
  wire  nmi_edge = sysctl_reg[SCRI_SC_NONMASKABLE_EDGE_SELECT] ? (nmi_s & ~nmi_d_reg)
                 : (~nmi_s & nmi_d_reg);

  // maskable external sources: irq0..2 then key request
  // key request from masked inputs
  wire       key_any_n = ~|(~key_s_n & ~kmask_reg);
  wire [3:0] line_n    = {key_any_n, irq_s_n};
  wire [3:0] sc_bits   = {sense_reg[6], sense_reg[2:0]};
  wire [3:0] en_bits   = {enable_reg[6], enable_reg[2:0]};
  logic [3:0] line_d_reg;
  logic [3:0] ext_pend_reg;
  logic [3:0] ext_req;
  logic [3:0] ext_take;

  // per-source sensing and pending flags
  // edge or level per source
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_src
      wire fall  = line_d_reg[gi] & ~line_n[gi];
      wire flush = cpu_imask & ~sc_bits[gi] & ~en_bits[gi];
      assign ext_req[gi] = sc_bits[gi] ? ext_pend_reg[gi]
                         : (~line_n[gi] & en_bits[gi]);
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          line_d_reg[gi]   <= 1'b1;
          ext_pend_reg[gi] <= 1'b0;
        end else if (clk_en) begin
          line_d_reg[gi] <= line_n[gi];
          if (core_reset) ext_pend_reg[gi] <= 1'b0;
          else if (fall && en_bits[gi] && sc_bits[gi]) ext_pend_reg[gi] <= 1'b1;
          else if (ext_take[gi] || flush) ext_pend_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // watchdog overflow interrupt, used when reset option is off
  logic wdt_pend_reg;
  logic wdt_take;
  logic nmi_take;

  // post-reset block: set by reset, cleared by a plain instruction
  logic blocked_reg;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      blocked_reg <= 1'b1;
    end else if (clk_en) begin
      if (core_reset) blocked_reg <= 1'b1;
      else if (cpu_instr_done && !cpu_cc_instr) blocked_reg <= 1'b0;
    end
  end

  // arbitration in fixed priority order
  // mask gates all but nonmaskable
  wire       mask_ok = ~cpu_imask & ~blocked_reg;
  wire       nmi_ok  = nmi_pend_reg & ~blocked_reg;
  wire [3:0] ext_ok  = ext_req & {4{mask_ok}};
  wire       wdt_ok  = wdt_pend_reg & mask_ok;
  wire       any_ok  = nmi_ok | (|ext_ok) | wdt_ok;
  // boundary only, not after cc instr
  wire       boundary = cpu_instr_done & ~cpu_cc_instr & ~core_reset;
  wire       take     = boundary & any_ok;
  logic [7:0] vec_sel;

  always_comb begin
    vec_sel  = SCRI_VEC_WDT;
    ext_take = 4'h0;
    nmi_take = 1'b0;
    wdt_take = 1'b0;
    if (nmi_ok) begin
      vec_sel  = SCRI_VEC_NMI;
      nmi_take = take;
    end else if (ext_ok[0]) begin
      vec_sel     = SCRI_VEC_IRQ0;
      ext_take[0] = take;
    end else if (ext_ok[1]) begin
      vec_sel     = SCRI_VEC_IRQ1;
      ext_take[1] = take;
    end else if (ext_ok[2]) begin
      vec_sel     = SCRI_VEC_IRQ2;
      ext_take[2] = take;
    end else if (ext_ok[3]) begin
      vec_sel     = SCRI_VEC_KEY;
      ext_take[3] = take;
    end else begin
      wdt_take = take;
    end
  end

  // nonmaskable and watchdog pending; a new event beats the clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      nmi_d_reg    <= 1'b1;
      nmi_pend_reg <= 1'b0;
      wdt_pend_reg <= 1'b0;
    end else if (clk_en) begin
      nmi_d_reg <= nmi_s;
      if (core_reset) begin
        nmi_pend_reg <= 1'b0;
        wdt_pend_reg <= 1'b0;
      end else begin
        if (nmi_edge) nmi_pend_reg <= 1'b1;
        else if (nmi_take) nmi_pend_reg <= 1'b0;
        if (wdt_overflow && !wdt_reset_select && wdt_irq_enable) wdt_pend_reg <= 1'b1;
        else if (wdt_take) wdt_pend_reg <= 1'b0;
      end
    end
  end

  // vector handed to the core with a one-cycle take strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      int_take   <= 1'b0;
      int_vector <= 8'h00;
    end else if (clk_en) begin
      int_take <= take;
      if (take) int_vector <= vec_sel;
    end
  end

  // power state and settling counter
  scri_pm_t              pm_reg;
  scri_pm_t              pm_next;
  logic [SCRI_SETW-1:0]  settle_reg;
  logic [SCRI_SETW-1:0]  settle_load;
  wire  [2:0]            sts = sysctl_reg[SCRI_SC_STS+2:SCRI_SC_STS];
  // wake from standby only on external sources
  wire  ext_wake = nmi_edge | (|(ext_req & en_bits));

  // select code to count; unused code acts as longest
  always_comb begin
    case (sts)
      3'b000:  settle_load = SCRI_SETW'(SETTLE_0);
      3'b001:  settle_load = SCRI_SETW'(SETTLE_1);
      3'b010:  settle_load = SCRI_SETW'(SETTLE_2);
      3'b011:  settle_load = SCRI_SETW'(SETTLE_3);
      default: settle_load = SCRI_SETW'(SETTLE_4);
    endcase
  end

  always_comb begin
    pm_next = pm_reg;
    case (pm_reg)
      SCRI_PM_RUN: begin
        if (cpu_halt_exec) begin
          pm_next = sysctl_reg[SCRI_SC_STBY] ? SCRI_PM_STBY : SCRI_PM_SLEEP;
        end
      end
      SCRI_PM_SLEEP: begin
        if (any_ok | nmi_edge) pm_next = SCRI_PM_RUN;
      end
      SCRI_PM_STBY: begin
        if (ext_wake) pm_next = SCRI_PM_SETTLE;
      end
      SCRI_PM_SETTLE: begin
        if (settle_reg == SCRI_SETW'(1)) pm_next = SCRI_PM_RUN;
      end
      default: pm_next = SCRI_PM_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pm_reg     <= SCRI_PM_RUN;
      settle_reg <= '0;
    end else if (clk_en) begin
      pm_reg <= core_reset ? SCRI_PM_RUN : pm_next;
      if (pm_reg == SCRI_PM_STBY) settle_reg <= settle_load;
      else if (settle_reg != '0) settle_reg <= settle_reg - SCRI_SETW'(1);
    end
  end

  assign cpu_halted    = pm_reg != SCRI_PM_RUN;
  assign periph_halted = pm_reg == SCRI_PM_STBY || pm_reg == SCRI_PM_SETTLE;

endmodule

`default_nettype wire

// File: hdl/scri_pkg.sv
// Purpose: shared constants and types for the system control block
// Assumes: 32-bit Avalon-MM slave, byte address = 4 * register index
// Notes:   settle counts are default values of top-level parameters
`default_nettype none

package scri_pkg;

  // register indexes; byte address is four times the index
  localparam logic [15:0] SCRI_IDX_SYSCTL = 16'hFFC4;
  localparam logic [15:0] SCRI_IDX_MODE   = 16'hFFC5;
  localparam logic [15:0] SCRI_IDX_SENSE  = 16'hFFC6;
  localparam logic [15:0] SCRI_IDX_ENABLE = 16'hFFC7;
  localparam logic [15:0] SCRI_IDX_KMASK  = 16'hFFF1;
  localparam int          SCRI_AW         = 18;

  // system_control field positions
  localparam int SCRI_SC_STBY  = 7;
  localparam int SCRI_SC_STS   = 4;
  localparam int SCRI_SC_SRC   = 3;
  localparam int SCRI_SC_NONMASKABLE_EDGE_SELECT = 2;
  localparam int SCRI_SC_HOST  = 1;
  localparam int SCRI_SC_RAM   = 0;

  // reset values and fixed read patterns
  localparam logic [7:0] SCRI_SC_RST    = 8'h09;
  localparam logic [7:0] SCRI_SC_WMASK  = 8'hF7;
  localparam logic [7:0] SCRI_IRQ_RST   = 8'hB8;
  localparam logic [7:0] SCRI_IRQ_RSVD  = 8'hB8;
  localparam logic [7:0] SCRI_KMASK_RST = 8'hFF;
  localparam logic [7:0] SCRI_MODE_FIX  = 8'hE4;

  // wake-up settling counts in states, one each for select codes 0 to 3, the last for codes 4 to 7
  localparam int unsigned SCRI_SETTLE_0 = 8192;
  localparam int unsigned SCRI_SETTLE_1 = 16384;
  localparam int unsigned SCRI_SETTLE_2 = 32768;
  localparam int unsigned SCRI_SETTLE_3 = 65536;
  localparam int unsigned SCRI_SETTLE_4 = 131072;
  localparam int          SCRI_SETW     = 18;

  // watchdog reset pulse width in clock cycles
  localparam logic [9:0] SCRI_WDT_RST_CYC = 10'd518;

  // vector numbers and reset vector address
  localparam logic [7:0]  SCRI_VEC_NMI   = 8'h03;
  localparam logic [7:0]  SCRI_VEC_IRQ0  = 8'h04;
  localparam logic [7:0]  SCRI_VEC_IRQ1  = 8'h05;
  localparam logic [7:0]  SCRI_VEC_IRQ2  = 8'h06;
  localparam logic [7:0]  SCRI_VEC_KEY   = 8'h0A;
  localparam logic [7:0]  SCRI_VEC_WDT   = 8'h2C;
  localparam logic [15:0] SCRI_RST_VADDR = 16'h0000;

  // power state of the core
  typedef enum logic [1:0] {
    SCRI_PM_RUN,
    SCRI_PM_SLEEP,
    SCRI_PM_STBY,
    SCRI_PM_SETTLE
  } scri_pm_t;

endpackage

`default_nettype wire

// File: testbench/scri_cpu_model.sv
// Purpose: cpu core stand-in that ends instructions and steers the mask
// Assumes: one instruction boundary every three cycles while running
// Notes:   cond-code kind and mask level are steered by the bench
`default_nettype none

module scri_cpu_model (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic core_reset,
  input  wire logic cpu_halted,
  input  wire logic cc_req,
  input  wire logic imask_req,
  output logic      cpu_instr_done,
  output logic      cpu_cc_instr,
  output logic      cpu_imask
);
  timeunit 1ns / 1ps;
  logic [1:0] ph_reg;

  // boundaries only while running, first one three cycles after reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ph_reg         <= 2'h0;
      cpu_instr_done <= 1'b0;
    end else begin
      ph_reg         <= (core_reset || cpu_halted || ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
      cpu_instr_done <= ph_reg == 2'h2 && !core_reset && !cpu_halted;
    end
  end

  // mask set by reset, otherwise as steered
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cpu_imask <= 1'b1;
    end else begin
      cpu_imask <= core_reset | imask_req;
    end
  end

  // kind is only meaningful with a boundary, so it flips in between
  assign cpu_cc_instr = cpu_instr_done ? cc_req : ~cc_req;
endmodule

`default_nettype wire

// File: testbench/scri_ctrl_sva.sv
// Purpose: port-level timing checks of the system control block
// Assumes: clk_en held high
// Notes:   bound onto every scri_ctrl instance
`default_nettype none

module scri_ctrl_sva
  import scri_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire logic [SCRI_AW-1:0] avs_address,
  input wire logic               avs_read,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  input wire logic               external_reset_pin_n,
  input wire logic               mode_pin_high,
  input wire logic               mode_pin_low,
  input wire logic               wdt_overflow,
  input wire logic               wdt_reset_select,
  input wire logic               cpu_instr_done,
  input wire logic               cpu_cc_instr,
  input wire logic               cpu_imask,
  input wire logic               core_reset,
  input wire logic               reset_seq_start,
  input wire logic [15:0]        reset_vector_addr,
  input wire logic               int_take,
  input wire logic [7:0]         int_vector
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // mode status read completing in this cycle
  wire logic mode_rd = avs_read && !avs_waitrequest && avs_address[17:2] == SCRI_IDX_MODE;

  chk_mode_fixed: assert property (
    mode_rd |-> avs_readdata[7:2] == SCRI_MODE_FIX[7:2]) else $error("mode fixed bits wrong");
  chk_mode_pins: assert property (
    mode_rd |-> avs_readdata[1:0] == {$past(mode_pin_high, 3), $past(mode_pin_low, 3)})
    else $error("mode bits differ from pins");
  chk_pin_reset: assert property (
    !external_reset_pin_n [*3] |-> core_reset) else $error("pin low without reset");
  chk_seq_start: assert property (
    $fell(core_reset) && !$past(reset) |=> reset_seq_start) else $error("no reset sequence");
  chk_vector_addr: assert property (
    reset_seq_start |-> !core_reset && reset_vector_addr == SCRI_RST_VADDR)
    else $error("bad reset vector");
  chk_take_edge: assert property (
    int_take |-> $past(cpu_instr_done) && !$past(cpu_cc_instr) && !$past(core_reset))
    else $error("take off a boundary");
  chk_take_once: assert property (
    int_take |=> !int_take) else $error("two takes in a row");
  chk_imask_nmi: assert property (
    int_take && $past(cpu_imask) |-> int_vector == SCRI_VEC_NMI) else $error("mask ignored");
  chk_vec_legal: assert property (
    int_take |-> int_vector inside {8'h03, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h2C})
    else $error("unknown vector");
  chk_wdt_pulse: assert property (
    wdt_overflow && wdt_reset_select && !core_reset |-> ##[1:2] core_reset [*8])
    else $error("watchdog reset missing");
endmodule

bind scri_ctrl scri_ctrl_sva scri_ctrl_sva_inst (.*);

`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: self-checking bench for the system control block
// Assumes: settle counts cut to 8..128 cycles
// Notes:   the cpu side is played by scri_cpu_model
`default_nettype none

module tb_top
  import scri_pkg::*;
;
  timeunit 1ns / 1ps;

  logic               sys_clk = 1'b0;
  logic               reset = 1'b1;
  logic               clk_en = 1'b1;
  logic [SCRI_AW-1:0] avs_address = '0;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0;
  logic [3:0]         avs_byteenable = 4'hF;
  logic               external_reset_pin_n = 1'b1;
  logic               nmi_pin = 1'b1;
  logic [2:0]         external_request_lines_n = 3'h7;
  logic [7:0]         key_sense_inputs_n = 8'hFF;
  logic               mode_pin_high = 1'b1, mode_pin_low = 1'b0;
  logic               wdt_overflow = 1'b0;
  logic               wdt_reset_select = 1'b0, wdt_irq_enable = 1'b0, cpu_halt_exec = 1'b0;
  logic               cc_req = 1'b0, imask_req = 1'b0;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest, cpu_instr_done, cpu_cc_instr, cpu_imask;
  logic               core_reset, reset_seq_start, int_take, cpu_halted, periph_halted;
  logic               host_port_enable, internal_ram_enable, rom_enable, vectors_external;
  logic               ext_bus_enable, addr_ports_default_in;
  logic [15:0]        reset_vector_addr;
  logic [7:0]         int_vector, d;
  int                 n_mismatch = 0, n_compared = 0, seed = 32'hd27b, t;

  scri_ctrl #(.SETTLE_0(8), .SETTLE_1(16), .SETTLE_2(32), .SETTLE_3(64), .SETTLE_4(128))
    scri_ctrl_inst (.*);
  scri_cpu_model scri_cpu_model_inst (.*);

  // 250 MHz
  always #2 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // one Avalon access; data taken at the edge waitrequest is low
  task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] x,
                     output logic [7:0] q);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, x};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [15:0] i, input logic [7:0] x);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    chk(q, x);
  endtask

  task automatic wt(input logic [15:0] i, input logic [7:0] x);
    logic [7:0] q;
    bus(1'b1, i, x, q);
  endtask

  // next vector within 40 cycles, or FF when none should come
  task automatic take(input logic [7:0] x);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (int_take !== 1'b1 && k < 40);
    chk(int_take === 1'b1 ? int_vector : 8'hFF, x);
    @(posedge sys_clk);
  endtask

  // cycles that core_reset (1) or cpu_halted (0) stays high
  task automatic count(input logic which, output int n);
    n = 0;
    do @(negedge sys_clk);
    while ((which ? core_reset : cpu_halted) !== 1'b1 && n++ < 20);
    n = 0;
    while ((which ? core_reset : cpu_halted) === 1'b1 && n < 2000) begin
      n++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
  endtask

  function automatic logic [7:0] prio(input logic [2:0] x, input logic [7:0] k);
    if (!x[0]) return SCRI_VEC_IRQ0;
    if (!x[1]) return SCRI_VEC_IRQ1;
    if (!x[2]) return SCRI_VEC_IRQ2;
    return k != 8'hFF ? SCRI_VEC_KEY : 8'hFF;
  endfunction

  // zero for sleep, otherwise the shortened settle count of the code
  function automatic int settle(input logic [3:0] v);
    if (!v[3]) return 0;
    return 8 << (v[2] ? 4 : v[1:0]);
  endfunction

  task automatic summarize;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected run
  initial begin
    #100000;
    chk(32'h0, 32'h1);
    summarize();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    count(1'b1, t);
    rd(SCRI_IDX_SYSCTL, SCRI_SC_RST);
    rd(16'h0000, 8'h00);
    // mode straps 1..3; outputs follow the latched bits
    for (int m = 1; m < 4; m++) begin
      {mode_pin_high, mode_pin_low} <= 2'(m);
      repeat (8) @(posedge sys_clk);
      rd(SCRI_IDX_MODE, SCRI_MODE_FIX | 8'(m));
      chk({rom_enable, vectors_external, ext_bus_enable}, m == 1 ? 3 : 7 - m);
      chk(addr_ports_default_in, m == 2);
    end
    wt(SCRI_IDX_MODE, 8'h1B);
    rd(SCRI_IDX_MODE, 8'hE7);
    // control bits: corners then random
    for (int i = 0; i < 8; i++) begin
      d = i == 0 ? 8'hFF : i == 1 ? 8'h00 : 8'($random(seed));
      wt(SCRI_IDX_SYSCTL, d);
      rd(SCRI_IDX_SYSCTL, d & SCRI_SC_WMASK | 8'h08);
      chk({host_port_enable, internal_ram_enable}, d[1:0]);
    end
    wt(SCRI_IDX_SYSCTL, 8'h01);
    wt(SCRI_IDX_SENSE, 8'h00);
    wt(SCRI_IDX_ENABLE, 8'h47);
    rd(SCRI_IDX_ENABLE, 8'hFF);
    rd(SCRI_IDX_SENSE, SCRI_IRQ_RSVD);
    // random level request mixes against the priority order
    for (int i = 0; i < 10; i++) begin
      external_request_lines_n <= 3'($random(seed));
      key_sense_inputs_n <= 8'($random(seed));
      d = 8'($random(seed));
      wt(SCRI_IDX_KMASK, d);
      repeat (6) @(posedge sys_clk);
      take(prio(external_request_lines_n, key_sense_inputs_n | d));
    end
    // masked: only the selected nonmaskable edge gets through
    external_request_lines_n <= 3'h0;
    imask_req <= 1'b1;
    repeat (4) @(posedge sys_clk);
    take(8'hFF);
    nmi_pin <= 1'b0;
    take(SCRI_VEC_NMI);
    nmi_pin <= 1'b1;
    take(8'hFF);
    wt(SCRI_IDX_SYSCTL, 8'h05);
    nmi_pin <= 1'b0;
    take(8'hFF);
    nmi_pin <= 1'b1;
    take(SCRI_VEC_NMI);
    external_request_lines_n <= 3'h7;
    key_sense_inputs_n <= 8'hFF;
    imask_req <= 1'b0;
    wdt_irq_enable <= 1'b1;
    repeat (6) @(posedge sys_clk);
    wdt_overflow <= 1'b1;
    @(posedge sys_clk);
    wdt_overflow <= 1'b0;
    take(SCRI_VEC_WDT);
    wt(SCRI_IDX_SENSE, 8'h01);
    external_request_lines_n <= 3'h6;
    take(SCRI_VEC_IRQ0);
    take(8'hFF);
    // watchdog reset: pulse width, source flag, ram bit reloaded
    wt(SCRI_IDX_SYSCTL, 8'h00);
    wdt_reset_select <= 1'b1;
    wdt_overflow <= 1'b1;
    @(posedge sys_clk);
    wdt_overflow <= 1'b0;
    count(1'b1, t);
    chk(t, 518);
    rd(SCRI_IDX_SYSCTL, 8'h01);
    wdt_reset_select <= 1'b0;
    // pin reset, then a cond-code first instruction keeps all blocked
    cc_req <= 1'b1;
    external_reset_pin_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    external_reset_pin_n <= 1'b1;
    count(1'b1, t);
    nmi_pin <= 1'b0;
    take(8'hFF);
    cc_req <= 1'b0;
    take(SCRI_VEC_NMI);
    rd(SCRI_IDX_SYSCTL, SCRI_SC_RST);
    nmi_pin <= 1'b1;
    wt(SCRI_IDX_ENABLE, 8'h01);
    // sleep, then standby codes 0, 2, 4 and unused 6
    for (int i = 0; i < 5; i++) begin
      external_request_lines_n <= 3'h7;
      d = i == 0 ? 8'h01 : {1'b1, 3'(2 * i - 2), 4'h1};
      wt(SCRI_IDX_SYSCTL, d);
      cpu_halt_exec <= 1'b1;
      @(posedge sys_clk);
      cpu_halt_exec <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk({cpu_halted, periph_halted}, {1'b1, d[7]});
      external_request_lines_n <= 3'h6;
      count(1'b0, t);
      chk(t >= settle(d[7:4]) && t <= settle(d[7:4]) + 12, 1'b1);
      chk(internal_ram_enable, 1'b1);
      repeat (12) @(posedge sys_clk);
    end
    summarize();
  end
endmodule

`default_nettype wire
